// ### testbench/tsa_adc_model.sv
`timescale 1ns/1ps
`default_nettype none
module tsa_adc_model
   import tsa_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        cs_n,
   input  wire logic        rd_n,
   input  wire logic        mode,
   input  wire logic        wr_n,
   input  wire logic [8:0]  ain,
   output logic             rdy_low,
   output logic             int_n,
   output logic             over_range_flag,
   output logic [7:0]       result_bus
);
   logic [8:0] smp_r = 9'h000;
   logic [7:0] res_r = 8'h00;
   logic       ovr_r = 1'b0, int_r = 1'b1, trk_r = 1'b0;
   logic       cvt_r = 1'b0, end_r = 1'b0;
   logic       wr_q = 1'b1, rd_q = 1'b1, cs_q = 1'b1;
   int         cnt_r = 0;
   logic       strb;
   // A floating mode pin reads as read-convert
   assign strb = (mode === 1'b1);
   // Open drain, no pull-up here: in read-convert mode, low from select until the end
   assign rdy_low = !strb && !cs_n && !end_r;
   assign int_n = int_r;
   assign over_range_flag = ovr_r;
   // A released bus shows the inverse, so stale data never passes
   assign result_bus = (!cs_n && !rd_n) ? res_r : ~res_r;
   // Sequencer sampled on the host clock
   always @(posedge sys_clk)
   begin
      wr_q <= wr_n;
      rd_q <= rd_n;
      cs_q <= cs_n;
      if ((rd_n && !rd_q) || (cs_n && !cs_q))
         int_r <= 1'b1;
      if (cs_n && !cs_q)
         end_r <= 1'b0;
      if (cvt_r)
         cnt_r <= cnt_r + 1;
      if (!cs_n && strb && wr_q && !wr_n)
      begin
         smp_r <= ain;
         trk_r <= 1'b1;
      end
      if (trk_r && wr_n)
      begin
         trk_r <= 1'b0;
         cvt_r <= 1'b1;
         cnt_r <= 1; // Rise is seen one edge late
      end
      if (!cs_n && !strb && rd_q && !rd_n)
      begin
         smp_r <= ain;
         end_r <= 1'b0;
         cvt_r <= 1'b1;
         cnt_r <= 0;
      end
      // Early read finishes at once, otherwise the internal delay
      if (cvt_r && (cnt_r == CONV_TIME_CYC - 1 ||
          (strb && rd_q && !rd_n && cnt_r >= EARLY_READ_CYC)))
      begin
         cvt_r <= 1'b0;
         res_r <= smp_r[8] ? 8'hff : smp_r[7:0];
         ovr_r <= smp_r[8];
         int_r <= 1'b0;
         end_r <= 1'b1;
      end
   end
endmodule // tsa_adc_model
`default_nettype wire

// ### testbench/tsa_host_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tsa_host_tb_top
   import tsa_pkg::*;
;
   logic       sys_clk = 1'b0, rst = 1'b1, req_valid = 1'b0;
   logic [1:0] req_op = 2'h0;
   logic [8:0] ain = 9'h000;
   logic       req_ready, rsp_over_range, rsp_valid, cs_n, rd_n, mode;
   logic       wr_out, wr_oe, rdy_in, rdy_low, int_n, ovr;
   logic [7:0] rsp_data, result_bus, prev_code = 8'h00;
   logic       prev_ovr = 1'b0, wr_q = 1'b1, int_q = 1'b1;
   int         miscompares = 0, n_checks = 0, cyc = 0, seed;
   int         low_cnt = 0, gap_cnt = 1000;
   always #2.5 sys_clk = ~sys_clk;
   // Board pull-up on the ready line feeds the wait input
   assign rdy_in = wr_oe ? wr_out : !rdy_low;
   tsa_host u_tsa_host (.sys_clk(sys_clk), .rst(rst),
      .req_valid(req_valid), .req_op(req_op), .req_ready(req_ready),
      .rsp_data(rsp_data), .rsp_over_range(rsp_over_range),
      .rsp_valid(rsp_valid), .cs_n(cs_n), .rd_n(rd_n), .mode(mode),
      .wr_out(wr_out), .wr_oe(wr_oe), .rdy_in(rdy_in), .int_n(int_n),
      .over_range_flag(ovr), .result_bus(result_bus));
   tsa_adc_model u_tsa_adc_model (.sys_clk(sys_clk), .cs_n(cs_n),
      .rd_n(rd_n), .mode(mode), .wr_n(rdy_in), .ain(ain),
      .rdy_low(rdy_low), .int_n(int_n), .over_range_flag(ovr),
      .result_bus(result_bus));
   task automatic chk_data(input logic [7:0] g, input logic [7:0] e);
      n_checks++;
      if (g !== e)
      begin
         miscompares++;
         $display("wrong value at %0t: data %h not %h", $time, g, e);
      end
   endtask
   task automatic chk_bit(input logic g, input logic e);
      n_checks++;
      if (g !== e)
      begin
         miscompares++;
         $display("wrong value at %0t: flag %b not %b", $time, g, e);
      end
   endtask
   task automatic chk_min(input int g, input int m);
      n_checks++;
      if (g < m)
      begin
         miscompares++;
         $display("wrong value at %0t: %0d cycles under %0d", $time, g, m);
      end
   endtask
   function automatic logic [7:0] exp_code(input logic [8:0] a);
      return a[8] ? 8'hff : a[7:0];
   endfunction
   task automatic conclude();
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // One request; pipelined reads hand back the previous result
   task automatic run_op(input logic [1:0] op, input logic [8:0] a);
      logic [7:0] e;
      logic       o;
      e = (op == OP_PIPELINED) ? prev_code : exp_code(a);
      o = (op == OP_PIPELINED) ? prev_ovr : a[8];
      ain = a;
      req_op = op;
      req_valid = 1'b1;
      while (req_ready !== 1'b1)
         @(negedge sys_clk);
      @(negedge sys_clk);
      req_valid = 1'b0;
      while (rsp_valid !== 1'b1)
         @(negedge sys_clk);
      chk_data(rsp_data, e);
      chk_bit(rsp_over_range, o);
      prev_code = exp_code(a);
      prev_ovr = a[8];
      @(negedge sys_clk);
   endtask
   // Strobe width, restart spacing and a run limit, seen on the wire
   always @(negedge sys_clk)
   begin
      cyc <= cyc + 1;
      int_q <= int_n;
      wr_q <= rdy_in | !wr_oe;
      low_cnt <= (rdy_in | !wr_oe) ? 0 : low_cnt + 1;
      gap_cnt <= (int_q && !int_n) ? 1 : gap_cnt + 1;
      if (!rst && wr_q && !(rdy_in | !wr_oe))
         chk_min(gap_cnt, RESTART_GAP_CYC);
      if (!rst && !wr_q && (rdy_in | !wr_oe))
         chk_min(low_cnt, START_LOW_CYC);
      if (cyc == 30000)
      begin
         miscompares++;
         conclude();
      end
   end
   initial
   begin
      seed = $urandom(32'hfff83843);
      repeat (5) @(negedge sys_clk);
      rst = 1'b0;
      @(negedge sys_clk);
      run_op(OP_INTERNAL, 9'h000);
      run_op(OP_EXTERNAL, 9'h0ff);
      run_op(OP_READ_CONVERT, 9'h1a5);
      run_op(OP_PIPELINED, 9'h05a);
      run_op(OP_PIPELINED, 9'h1c3);
      repeat (12) run_op(2'($urandom), 9'($urandom));
      conclude();
   end
endmodule // tsa_host_tb_top
`default_nettype wire

// ### verilog/tsa_host.sv
// Operation
// - Start strobe falling edge begins tracking
// - Hold start strobe low 600 ns
// - Early read allowed 600 ns after start
// - Wait 500 ns after done
// - Read-convert: read held until result
// - Strobed: read with select low after done
// - Tied strobes read previous, start new
`timescale 1ns/1ps
`default_nettype none
module tsa_host
   import tsa_pkg::*;
(
   input  wire logic              sys_clk,
   input  wire logic              rst,
   input  wire logic              req_valid,
   input  wire logic [1:0]        req_op,
   output logic                   req_ready,
   output logic [DATA_W-1:0]      rsp_data,
   output logic                   rsp_over_range,
   output logic                   rsp_valid,
   output logic                   cs_n,
   output logic                   rd_n,
   output logic                   mode,
   output logic                   wr_out,
   output logic                   wr_oe,
   input  wire logic              rdy_in,
   input  wire logic              int_n,
   input  wire logic              over_range_flag,
   input  wire logic [DATA_W-1:0] result_bus
);
   // Two-flop synchronisers for every converter output
   logic [DATA_W+2:0] sync1_r;
   logic [DATA_W+2:0] sync2_r;
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         sync1_r <= 11'h7ff;
         sync2_r <= 11'h7ff;
      end
      else
      begin
         sync1_r <= {rdy_in, int_n, over_range_flag, result_bus};
         sync2_r <= sync1_r;
      end
   end
   logic              rdy_s;
   logic              int_s;
   logic              ofl_s;
   logic [DATA_W-1:0] bus_s;
   assign rdy_s = sync2_r[DATA_W+2];
   assign int_s = sync2_r[DATA_W+1];
   assign ofl_s = sync2_r[DATA_W];
   assign bus_s = sync2_r[DATA_W-1:0];

   tsa_state_t       st_r, st_nxt;
   logic [CNT_W-1:0] cnt_r, cnt_nxt;
   logic [1:0]       op_r, op_nxt;
   logic             cs_n_r, cs_n_nxt, rd_n_r, rd_n_nxt;
   logic             wr_r, wr_nxt, mode_r, mode_nxt;
   logic [DATA_W-1:0] dat_r, dat_nxt;
   logic             ofl_r, ofl_nxt, vld_r, vld_nxt;
   logic             rdy_r;

   // Sequencer; the host paces the converter by cycle counts, with done
   // sampled to end conversion waits early and ready awaited in read-convert.
   always_comb
   begin
      st_nxt   = st_r;
      cnt_nxt  = cnt_r;
      op_nxt   = op_r;
      cs_n_nxt = cs_n_r;
      rd_n_nxt = rd_n_r;
      wr_nxt   = wr_r;
      mode_nxt = mode_r;
      dat_nxt  = dat_r;
      ofl_nxt  = ofl_r;
      vld_nxt  = 1'b0;
      unique case (st_r)
         ST_IDLE:
         begin
            // Ready is low for a cycle after reset; nothing is taken then
            if (req_valid && rdy_r)
            begin
               op_nxt   = req_op;
               cnt_nxt  = '0;
               cs_n_nxt = 1'b0;
               // Low selects read-convert, high strobed
               mode_nxt = (req_op != OP_READ_CONVERT);
               if (req_op == OP_READ_CONVERT)
               begin
                  rd_n_nxt = 1'b0;
                  st_nxt   = ST_RDWAIT;
               end
               else
               begin
                  wr_nxt = 1'b0;
                  if (req_op == OP_PIPELINED)
                     rd_n_nxt = 1'b0;
                  st_nxt = ST_TRACK;
               end
            end
         end
         ST_TRACK:
         begin
            cnt_nxt = cnt_r + 1'b1;
            if (cnt_r == CNT_W'(START_LOW_CYC - 1))
            begin
               wr_nxt  = 1'b1;
               cnt_nxt = '0;
               if (op_r == OP_PIPELINED)
               begin
                  // Previous result is on the bus now
                  rd_n_nxt = 1'b1;
                  dat_nxt  = bus_s;
                  ofl_nxt  = ofl_s;
                  vld_nxt  = 1'b1;
                  // New conversion still runs; wait for its done
                  st_nxt   = ST_CONV;
               end
               else
                  st_nxt = ST_CONV;
            end
         end
         ST_CONV:
         begin
            cnt_nxt = cnt_r + 1'b1;
            if (op_r == OP_EXTERNAL &&
                cnt_r == CNT_W'(EARLY_READ_CYC - 1))
            begin
               rd_n_nxt = 1'b0;
               cnt_nxt  = '0;
               st_nxt   = ST_READ;
            end
            // Timeout too, since done travels two sync flops late
            else if (op_r == OP_INTERNAL &&
                     (!int_s || cnt_r == CNT_W'(CONV_TIME_CYC + 3)))
            begin
               rd_n_nxt = 1'b0;
               cnt_nxt  = '0;
               st_nxt   = ST_READ;
            end
            // Pipelined restart must wait for done, then the full gap
            else if (op_r == OP_PIPELINED &&
                     (!int_s || cnt_r == CNT_W'(CONV_TIME_CYC + 3)))
            begin
               cnt_nxt = '0;
               st_nxt  = ST_HOLD;
            end
         end
         ST_READ:
         begin
            // Bus settles, then two sync flops
            cnt_nxt = cnt_r + 1'b1;
            if (cnt_r == CNT_W'(15))
            begin
               dat_nxt  = bus_s;
               ofl_nxt  = ofl_s;
               vld_nxt  = 1'b1;
               rd_n_nxt = 1'b1;
               cnt_nxt  = '0;
               st_nxt   = ST_HOLD;
            end
         end
         ST_RDWAIT:
         begin
            // Ready released high ends the wait
            cnt_nxt = cnt_r + 1'b1;
            if (cnt_r > CNT_W'(4) && rdy_s)
            begin
               cnt_nxt = '0;
               st_nxt  = ST_READ;
            end
         end
         ST_HOLD:
         begin
            cs_n_nxt = 1'b1;
            cnt_nxt  = '0;
            st_nxt   = ST_GAP;
         end
         ST_GAP:
         begin
            cnt_nxt = cnt_r + 1'b1;
            if (cnt_r == CNT_W'(RESTART_GAP_CYC - 1))
            begin
               cs_n_nxt = 1'b1;
               cnt_nxt  = '0;
               st_nxt   = ST_IDLE;
            end
         end
      endcase
   end

   // Registers only
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         st_r   <= ST_IDLE;
         cnt_r  <= '0;
         op_r   <= OP_INTERNAL;
         cs_n_r <= 1'b1;
         rd_n_r <= 1'b1;
         wr_r   <= 1'b1;
         mode_r <= 1'b1;
         dat_r  <= 8'h00;
         ofl_r  <= 1'b0;
         vld_r  <= 1'b0;
      end
      else
      begin
         st_r   <= st_nxt;
         cnt_r  <= cnt_nxt;
         op_r   <= op_nxt;
         cs_n_r <= cs_n_nxt;
         rd_n_r <= rd_n_nxt;
         wr_r   <= wr_nxt;
         mode_r <= mode_nxt;
         dat_r  <= dat_nxt;
         ofl_r  <= ofl_nxt;
         vld_r  <= vld_nxt;
      end
   end

   // Ready register loads from the next state, so it tracks idle with no lag
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         rdy_r <= 1'b0;
      else
         rdy_r <= (st_nxt == ST_IDLE);
   end

   assign req_ready      = rdy_r;
   assign rsp_data       = dat_r;
   assign rsp_over_range = ofl_r;
   assign rsp_valid      = vld_r;
   assign cs_n           = cs_n_r;
   assign rd_n           = rd_n_r;
   assign mode           = mode_r;
   assign wr_out         = wr_r;
   // Pin is an input of ours in read-convert mode
   assign wr_oe          = mode_r;

   // Start strobe stays low at least 8 cycles once it falls
   start_low_a : assert property (@(posedge sys_clk) disable iff (rst)
      $fell(wr_r) |-> !wr_r [*8]) else $error("start strobe short");
   // Gap before next start after a read
   restart_gap_a : assert property (@(posedge sys_clk) disable iff (rst)
      $rose(cs_n_r) |-> cs_n_r [*8]) else $error("restart gap short");
   // Strobes only with select low
   strobe_sel_a : assert property (@(posedge sys_clk) disable iff (rst)
      (!rd_n_r || !wr_r) |-> !cs_n_r) else $error("strobe unselected");
   // Early read not within 8 cycles of the start strobe rising
   early_read_a : assert property (@(posedge sys_clk) disable iff (rst)
      $rose(wr_r) && op_r == OP_EXTERNAL |-> rd_n_r [*8])
      else $error("read too early");
   // Read-convert mode never drives shared pin
   rc_mode_a : assert property (@(posedge sys_clk) disable iff (rst)
      !mode_r |-> !wr_oe && wr_r)
      else $error("pin driven in read mode");
   // Result valid only one cycle
   rsp_pulse_a : assert property (@(posedge sys_clk) disable iff (rst)
      rsp_valid |=> !rsp_valid) else $error("valid not a pulse");
   // Read ends before select
   done_clear_a : assert property (@(posedge sys_clk) disable iff (rst)
      $rose(cs_n_r) |-> rd_n_r) else $error("select rose during read");
   // Internal-mode read not within 8 cycles of the start strobe rising
   conv_wait_a : assert property (@(posedge sys_clk) disable iff (rst)
      $rose(wr_r) && op_r == OP_INTERNAL |-> rd_n_r [*8])
      else $error("read before conversion");
endmodule // tsa_host
`default_nettype wire

// ### verilog/tsa_pkg.sv
package tsa_pkg;
   // Pin timing in ns as the converter wants it
   localparam int unsigned CLK_PERIOD_NS   = 5;
   localparam int unsigned START_LOW_NS    = 600;
   localparam int unsigned EARLY_READ_NS   = 600;
   localparam int unsigned CONV_TIME_NS    = 700;
   localparam int unsigned RESTART_GAP_NS  = 500;
   // Least times round up to whole cycles
   localparam int unsigned START_LOW_CYC   =
      (START_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned EARLY_READ_CYC  =
      (EARLY_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned CONV_TIME_CYC   =
      (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned RESTART_GAP_CYC =
      (RESTART_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned CNT_W           = 9;
   localparam int unsigned DATA_W          = 8;
   // Mode request encodings
   localparam logic [1:0] OP_INTERNAL     = 2'h0;
   localparam logic [1:0] OP_EXTERNAL     = 2'h1;
   localparam logic [1:0] OP_READ_CONVERT = 2'h2;
   localparam logic [1:0] OP_PIPELINED    = 2'h3;

   typedef enum logic [6:0] {
      ST_IDLE   = 7'h01,
      ST_TRACK  = 7'h02,
      ST_CONV   = 7'h04,
      ST_READ   = 7'h08,
      ST_RDWAIT = 7'h10,
      ST_HOLD   = 7'h20,
      ST_GAP    = 7'h40
   } tsa_state_t;
endpackage
